// ==== core/exec_pkg.sv ====
// Shared constants, field layouts and carrier types of the instruction execute unit
package exec_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Register byte offsets
    localparam logic [11:0] OFS_CTRL     = 12'h000;
    localparam logic [11:0] OFS_INSTR    = 12'h004;
    localparam logic [11:0] OFS_STATUS   = 12'h008;
    localparam logic [11:0] OFS_ACC      = 12'h00c;
    localparam logic [11:0] OFS_FLAGS    = 12'h010;
    localparam logic [11:0] OFS_PC       = 12'h014;
    localparam logic [11:0] OFS_INTCTL   = 12'h018;
    localparam logic [11:0] OFS_MEM_ADDR = 12'h01c;
    localparam logic [11:0] OFS_MEM_DATA = 12'h020;
    localparam logic [11:0] OFS_STACK    = 12'h024;
    localparam logic [11:0] OFS_WDT      = 12'h028;

    ////////////////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int CTRL_GO_BIT     = 0;
    localparam int CTRL_WAKE_BIT   = 1;
    localparam int STAT_BUSY_BIT   = 0;
    localparam int STAT_HALT_BIT   = 1;
    localparam int STAT_SP_LSB     = 8;
    localparam int GIE_BIT         = 0;
    localparam int INSTR_OP_LSB    = 0;
    localparam int INSTR_OP_W      = 5;
    localparam int INSTR_OPND_LSB  = 5;
    localparam int INSTR_OPND_W    = 12;
    localparam int JUMP_W          = 12;
    localparam int FLAGS_W         = 4;
    localparam int WDT_LSB         = 0;
    localparam int PRESC_LSB       = 8;

    ////////////////////////////////////////////////////////////////////////////////
    // Widths, reset values and counts
    localparam int WDT_W   = 8;
    localparam int PRESC_W = 8;
    localparam logic [7:0]  ACC_RST       = 8'h00;
    localparam logic [3:0]  FLAGS_RST     = 4'h0;
    localparam logic        GIE_RST       = 1'b0;
    localparam logic [WDT_W-1:0]   WDT_RST   = 8'h00;
    localparam logic [PRESC_W-1:0] PRESC_RST = 8'h00;
    localparam int RETURN_CYCLES = 2;

    ////////////////////////////////////////////////////////////////////////////////
    // Opcodes
    localparam logic [4:0] OP_NO_OPERATION                  = 5'h00;
    localparam logic [4:0] OP_POWER_DOWN                    = 5'h01;
    localparam logic [4:0] OP_INCREMENT_MEMORY              = 5'h02;
    localparam logic [4:0] OP_INCREMENT_TO_ACCUMULATOR      = 5'h03;
    localparam logic [4:0] OP_JUMP                          = 5'h04;
    localparam logic [4:0] OP_MOVE_MEM_TO_ACC               = 5'h05;
    localparam logic [4:0] OP_MOVE_IMM_TO_ACC               = 5'h06;
    localparam logic [4:0] OP_MOVE_ACC_TO_MEM               = 5'h07;
    localparam logic [4:0] OP_OR_MEM_TO_ACC                 = 5'h08;
    localparam logic [4:0] OP_OR_IMM_TO_ACC                 = 5'h09;
    localparam logic [4:0] OP_OR_INTO_MEMORY                = 5'h0a;
    localparam logic [4:0] OP_RETURN                        = 5'h0b;
    localparam logic [4:0] OP_RETURN_WITH_CONST             = 5'h0c;
    localparam logic [4:0] OP_INTERRUPT_RETURN              = 5'h0d;
    localparam logic [4:0] OP_ROTATE_LEFT                   = 5'h0e;
    localparam logic [4:0] OP_ROTATE_LEFT_TO_ACCUMULATOR    = 5'h0f;
    localparam logic [4:0] OP_ROTATE_LEFT_THROUGH_CARRY     = 5'h10;
    localparam logic [4:0] OP_ROTATE_LEFT_CARRY_TO_ACCUMULATOR = 5'h11;
    localparam logic [4:0] OP_ROTATE_RIGHT                  = 5'h12;
    localparam logic [4:0] OP_ROTATE_RIGHT_TO_ACCUMULATOR   = 5'h13;
    localparam logic [4:0] OP_ROTATE_RIGHT_THROUGH_CARRY    = 5'h14;

    ////////////////////////////////////////////////////////////////////////////////
    // Carriers
    typedef struct packed {
        logic watchdog_timeout_flag;
        logic power_down_flag;
        logic carry;
        logic zero;
    } flags_t;

    typedef struct packed {
        logic [INSTR_OPND_W-1:0] operand;
        logic [INSTR_OP_W-1:0]   opcode;
    } instr_t;

endpackage

// ==== core/exec_unit.sv ====
// Instruction execute unit with APB register access, data memory and return stack
//
// What this block does
// RL1 - Power-down halts execution, stops clock; RAM and registers keep their values.
// RL2 - Power-down clears watchdog and prescaler, sets power-down flag, clears timeout unless the watchdog overflows that cycle, PC+1.
// RL3 - Memory increment writes byte plus one back; only zero flag changes.
// RL4 - Increment-to-accumulator puts byte plus one in accumulator; memory kept; zero flag only.
// RL5 - Direct jump replaces PC bits 0..11 with instruction address; no flags change.
// RL6 - Memory-to-accumulator move copies byte into accumulator; flags untouched.
// RL7 - Immediate move loads the 8-bit instruction constant into accumulator; flags untouched.
// RL8 - Accumulator-to-memory move stores accumulator into addressed byte; flags untouched.
// RL9 - No-operation only advances PC by one.
// RL10 - OR with memory into accumulator; only zero flag changes.
// RL11 - OR with immediate into accumulator; only zero flag changes.
// RL12 - OR into memory stores accumulator OR byte back; only zero flag changes.
// RL13 - Subroutine return reloads PC from stack top, takes two cycles, flags kept.
// RL14 - Return-with-constant reloads PC from stack and loads immediate into accumulator.
// RL15 - Interrupt return reloads PC from stack and sets global interrupt enable bit 0.
// RL16 - Rotate left in memory, bit 7 into bit 0, no flags.
// RL17 - Rotate left into accumulator, bit 7 wraps to bit 0; memory, flags kept.
// RL18 - Rotate left through carry in memory; old carry to bit 0, bit 7 to carry.
// RL19 - Rotate left through carry into accumulator; bit 7 to carry; memory kept.
// RL20 - Rotate right in memory, bit 0 into bit 7, no flags.
// RL21 - Rotate right into accumulator, bit 0 wraps to bit 7; memory, flags kept.
// RL22 - Rotate right through carry in memory; old carry to bit 7, bit 0 to carry.
// RL23 - Zero flag set when 8-bit result is zero, cleared otherwise.
`timescale 1ns/1ps

module exec_unit
    import exec_pkg::*;
#(
    parameter int PC_W        = 12,
    parameter int STACK_DEPTH = 4,
    parameter int DMEM_DEPTH  = 128
) (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Core status
    output logic             clock_stop,
    output logic             global_interrupt_enable
);

    localparam int SP_W = $clog2(STACK_DEPTH);
    localparam int DA_W = $clog2(DMEM_DEPTH);

    initial begin
        if (PC_W < JUMP_W || PC_W > 16)
            $error("PC_W must lie between 12 and 16");
        if (STACK_DEPTH < 2 || (1 << SP_W) != STACK_DEPTH)
            $error("STACK_DEPTH must be a power of two, at least 2");
        if (DMEM_DEPTH < 2 || DMEM_DEPTH > 256 || (1 << DA_W) != DMEM_DEPTH)
            $error("DMEM_DEPTH must be a power of two from 2 to 256");
    end

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_EXEC,
        ST_RETURN,
        ST_HALTED
    } state_t;

    ////////////////////////////////////////////////////////////////////////////////
    // Storage
    state_t                state_q;
    state_t                state_d;
    instr_t                instr_q;
    flags_t                flags_q;
    logic [7:0]            acc_q;
    logic [PC_W-1:0]       pc_q;
    logic                  gie_q;
    logic [DA_W-1:0]       mem_addr_q;
    logic [SP_W-1:0]       sp_q;
    logic [WDT_W-1:0]      wdt_q;
    logic [PRESC_W-1:0]    presc_q;
    logic                  pready_q;
    logic                  pslverr_q;
    logic [31:0]           prdata_q;
    logic                  clock_stop_q;
    logic [7:0]            dmem [DMEM_DEPTH];
    logic [PC_W-1:0]       stack_mem [STACK_DEPTH];

    ////////////////////////////////////////////////////////////////////////////////
    // APB decode
    logic                  commit;
    logic                  wr_commit;
    logic                  sw_ok;
    logic                  addr_hit;
    logic [31:0]           rd_mux;

    assign commit    = psel & penable & pready_q;
    assign wr_commit = commit & pwrite;
    // Engine-owned state only accepts software writes while the engine is idle
    assign sw_ok     = (state_q == ST_IDLE);

    always_comb begin
        addr_hit = 1'b1;
        rd_mux   = 32'h0000_0000;
        case (paddr)
            OFS_CTRL:     rd_mux = 32'h0000_0000;
            OFS_INSTR:    rd_mux = 32'(instr_q);
            OFS_STATUS: begin
                rd_mux[STAT_BUSY_BIT]                = (state_q == ST_EXEC) || (state_q == ST_RETURN);
                rd_mux[STAT_HALT_BIT]                = (state_q == ST_HALTED);
                rd_mux[STAT_SP_LSB +: SP_W]          = sp_q;
            end
            OFS_ACC:      rd_mux = 32'(acc_q);
            OFS_FLAGS:    rd_mux = 32'(flags_q);
            OFS_PC:       rd_mux = 32'(pc_q);
            OFS_INTCTL:   rd_mux[GIE_BIT] = gie_q;
            OFS_MEM_ADDR: rd_mux = 32'(mem_addr_q);
            OFS_MEM_DATA: rd_mux = 32'(dmem[mem_addr_q]);
            OFS_STACK:    rd_mux = 32'(stack_mem[sp_q - 1'b1]);
            OFS_WDT: begin
                rd_mux[WDT_LSB +: WDT_W]     = wdt_q;
                rd_mux[PRESC_LSB +: PRESC_W] = presc_q;
            end
            default:      addr_hit = 1'b0;
        endcase
    end

    // One wait state: pready rises in the second access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end else begin
            pready_q  <= psel & penable & ~pready_q;
            pslverr_q <= psel & penable & ~pready_q & ~addr_hit;
            if (psel && penable && !pready_q && !pwrite)
                prdata_q <= rd_mux;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Instruction decode and datapath
    logic [DA_W-1:0]       op_addr;
    logic [7:0]            op_imm;
    logic [7:0]            mem_rd;
    logic [7:0]            result;
    logic                  wr_mem;
    logic                  wr_acc;
    logic                  upd_zero;
    logic                  upd_carry;
    logic                  new_carry;
    logic                  is_return;
    logic                  is_jump;
    logic                  is_power_down;

    assign op_addr = instr_q.operand[DA_W-1:0];
    assign op_imm  = instr_q.operand[7:0];
    assign mem_rd  = dmem[op_addr];

    always_comb begin
        result        = 8'h00;
        wr_mem        = 1'b0;
        wr_acc        = 1'b0;
        upd_zero      = 1'b0;
        upd_carry     = 1'b0;
        new_carry     = flags_q.carry;
        is_return     = 1'b0;
        is_jump       = 1'b0;
        is_power_down = 1'b0;
        case (instr_q.opcode)
            OP_POWER_DOWN: is_power_down = 1'b1; // [RL1]
            OP_INCREMENT_MEMORY: begin
                result   = mem_rd + 8'h01; // [RL3]
                wr_mem   = 1'b1;
                upd_zero = 1'b1;
            end
            OP_INCREMENT_TO_ACCUMULATOR: begin
                result   = mem_rd + 8'h01; // [RL4]
                wr_acc   = 1'b1;
                upd_zero = 1'b1;
            end
            OP_JUMP: is_jump = 1'b1; // [RL5]
            OP_MOVE_MEM_TO_ACC: begin
                result = mem_rd; // [RL6]
                wr_acc = 1'b1;
            end
            OP_MOVE_IMM_TO_ACC: begin
                result = op_imm; // [RL7]
                wr_acc = 1'b1;
            end
            OP_MOVE_ACC_TO_MEM: begin
                result = acc_q; // [RL8]
                wr_mem = 1'b1;
            end
            OP_OR_MEM_TO_ACC: begin
                result   = acc_q | mem_rd; // [RL10]
                wr_acc   = 1'b1;
                upd_zero = 1'b1;
            end
            OP_OR_IMM_TO_ACC: begin
                result   = acc_q | op_imm; // [RL11]
                wr_acc   = 1'b1;
                upd_zero = 1'b1;
            end
            OP_OR_INTO_MEMORY: begin
                result   = acc_q | mem_rd; // [RL12]
                wr_mem   = 1'b1;
                upd_zero = 1'b1;
            end
            OP_RETURN: is_return = 1'b1; // [RL13]
            OP_RETURN_WITH_CONST: begin
                is_return = 1'b1; // [RL14]
                result    = op_imm;
                wr_acc    = 1'b1;
            end
            OP_INTERRUPT_RETURN: is_return = 1'b1; // [RL15]
            OP_ROTATE_LEFT: begin
                result = {mem_rd[6:0], mem_rd[7]}; // [RL16]
                wr_mem = 1'b1;
            end
            OP_ROTATE_LEFT_TO_ACCUMULATOR: begin
                result = {mem_rd[6:0], mem_rd[7]}; // [RL17]
                wr_acc = 1'b1;
            end
            OP_ROTATE_LEFT_THROUGH_CARRY: begin
                result    = {mem_rd[6:0], flags_q.carry}; // [RL18]
                wr_mem    = 1'b1;
                upd_carry = 1'b1;
                new_carry = mem_rd[7];
            end
            OP_ROTATE_LEFT_CARRY_TO_ACCUMULATOR: begin
                result    = {mem_rd[6:0], flags_q.carry}; // [RL19]
                wr_acc    = 1'b1;
                upd_carry = 1'b1;
                new_carry = mem_rd[7];
            end
            OP_ROTATE_RIGHT: begin
                result = {mem_rd[0], mem_rd[7:1]}; // [RL20]
                wr_mem = 1'b1;
            end
            OP_ROTATE_RIGHT_TO_ACCUMULATOR: begin
                result = {mem_rd[0], mem_rd[7:1]}; // [RL21]
                wr_acc = 1'b1;
            end
            OP_ROTATE_RIGHT_THROUGH_CARRY: begin
                result    = {flags_q.carry, mem_rd[7:1]}; // [RL22]
                wr_mem    = 1'b1;
                upd_carry = 1'b1;
                new_carry = mem_rd[0];
            end
            // Unassigned codes fall through as a no-operation
            default: ; // [RL9]
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Sequencing
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE:
                if (wr_commit && paddr == OFS_CTRL && pwdata[CTRL_GO_BIT])
                    state_d = ST_EXEC;
            ST_EXEC:
                if (is_power_down)
                    state_d = ST_HALTED; // [RL1]
                else if (is_return)
                    state_d = ST_RETURN; // [RL13]
                else
                    state_d = ST_IDLE;
            ST_RETURN:
                state_d = ST_IDLE;
            ST_HALTED:
                // Only a wake request restarts the core; go is ignored here
                if (wr_commit && paddr == OFS_CTRL && pwdata[CTRL_WAKE_BIT])
                    state_d = ST_IDLE;
            default:
                state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q      <= ST_IDLE;
            clock_stop_q <= 1'b0;
        end else begin
            state_q      <= state_d;
            clock_stop_q <= (state_d == ST_HALTED); // [RL1]
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            instr_q <= '0;
        else if (wr_commit && sw_ok && paddr == OFS_INSTR)
            instr_q <= pwdata[INSTR_OP_LSB +: INSTR_OP_W + INSTR_OPND_W];
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Accumulator, program counter, interrupt enable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            acc_q <= ACC_RST;
        else if (state_q == ST_EXEC && wr_acc)
            acc_q <= result;
        else if (wr_commit && sw_ok && paddr == OFS_ACC)
            acc_q <= pwdata[7:0];
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            pc_q <= '0;
        else if (state_q == ST_EXEC) begin
            if (is_jump)
                pc_q[JUMP_W-1:0] <= instr_q.operand[JUMP_W-1:0]; // [RL5]
            else if (is_return)
                pc_q <= stack_mem[sp_q - 1'b1]; // [RL13]
            else
                pc_q <= pc_q + 1'b1; // [RL2] [RL9]
        end else if (wr_commit && sw_ok && paddr == OFS_PC)
            pc_q <= pwdata[PC_W-1:0];
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            gie_q <= GIE_RST;
        else if (state_q == ST_EXEC && instr_q.opcode == OP_INTERRUPT_RETURN)
            gie_q <= 1'b1; // [RL15]
        else if (wr_commit && sw_ok && paddr == OFS_INTCTL)
            gie_q <= pwdata[GIE_BIT];
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Return stack; software pushes return addresses, returns pop them
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            sp_q <= '0;
        else if (state_q == ST_EXEC && is_return)
            sp_q <= sp_q - 1'b1;
        else if (wr_commit && sw_ok && paddr == OFS_STACK)
            sp_q <= sp_q + 1'b1;
    end

    // Circular like a hardware stack: an overflow overwrites the oldest entry
    always_ff @(posedge pclk) begin
        if (wr_commit && sw_ok && paddr == OFS_STACK)
            stack_mem[sp_q] <= pwdata[PC_W-1:0];
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Data memory; not reset, contents survive power-down
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            mem_addr_q <= '0;
        else if (wr_commit && sw_ok && paddr == OFS_MEM_ADDR)
            mem_addr_q <= pwdata[DA_W-1:0];
    end

    always_ff @(posedge pclk) begin
        if (state_q == ST_EXEC && wr_mem)
            dmem[op_addr] <= result;
        else if (wr_commit && sw_ok && paddr == OFS_MEM_DATA)
            dmem[mem_addr_q] <= pwdata[7:0];
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Watchdog; frozen while halted since the core clock is stopped
    logic wdt_ovf;

    assign wdt_ovf = (state_q != ST_HALTED) && (&presc_q) && (&wdt_q);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            presc_q <= PRESC_RST;
            wdt_q   <= WDT_RST;
        end else if (state_q == ST_EXEC && is_power_down) begin
            presc_q <= PRESC_RST; // [RL2]
            wdt_q   <= WDT_RST;
        end else if (state_q != ST_HALTED) begin
            presc_q <= presc_q + 1'b1;
            if (&presc_q)
                wdt_q <= wdt_q + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Status flags
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            flags_q <= FLAGS_RST;
        else begin
            if (state_q == ST_EXEC) begin
                if (upd_zero)
                    flags_q.zero <= (result == 8'h00); // [RL23]
                if (upd_carry)
                    flags_q.carry <= new_carry; // [RL18] [RL19] [RL22]
                if (is_power_down) begin
                    flags_q.power_down_flag       <= 1'b1; // [RL2]
                    flags_q.watchdog_timeout_flag <= 1'b0;
                end
            end else if (wr_commit && sw_ok && paddr == OFS_FLAGS)
                flags_q <= pwdata[FLAGS_W-1:0];
            // Timeout set wins over any clear in the same cycle
            if (wdt_ovf)
                flags_q.watchdog_timeout_flag <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs
    assign prdata                  = prdata_q;
    assign pready                  = pready_q;
    assign pslverr                 = pslverr_q;
    assign clock_stop              = clock_stop_q;
    assign global_interrupt_enable = gie_q;

endmodule

// ==== testbench/exec_unit_sva.sv ====
// Bus timing and execution checks bound to the execute unit
`timescale 1ns/1ps
module exec_unit_sva
    import exec_pkg::*;
(
    // Clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // APB
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Core status
    input wire logic        clock_stop,
    input wire logic        global_interrupt_enable
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic done;
    logic go;
    logic wk;
    logic gw;
    assign done = psel && penable && pready;
    assign go   = done && pwrite && paddr == OFS_CTRL && pwdata[CTRL_GO_BIT];
    assign wk   = done && pwrite && paddr == OFS_CTRL && pwdata[CTRL_WAKE_BIT];
    assign gw   = done && pwrite && paddr == OFS_INTCTL;
    ////////////////////////////////////////////////////////////////////////////////
    wait_state_a: assert property ($rose(penable) && psel |-> !pready ##1 pready) else $error("wait state");
    err_pulse_a: assert property (pslverr |-> pready) else $error("stray error");
    unmapped_err_a: assert property (done && paddr > OFS_WDT |-> pslverr && (pwrite || prdata == 32'h0))
        else $error("unmapped access");
    ctrl_read_a: assert property (done && !pwrite && paddr == OFS_CTRL |-> prdata == 32'h0 && !pslverr)
        else $error("control read");
    stop_hold_a: assert property (clock_stop && !wk |=> clock_stop) else $error("halt lost");
    stop_wake_a: assert property (clock_stop && wk |=> !clock_stop) else $error("no wake");
    stop_cause_a: assert property ($rose(clock_stop) |-> $past(go, 2)) else $error("halt late");
    halt_status_a: assert property (done && !pwrite && paddr == OFS_STATUS |-> prdata[STAT_HALT_BIT] == clock_stop)
        else $error("halt status");
    gie_fall_a: assert property ($fell(global_interrupt_enable) |-> $past(gw)) else $error("enable fell");
    gie_rise_a: assert property ($rose(global_interrupt_enable) |-> $past(gw) || $past(go, 2) || $past(go, 3))
        else $error("enable rose");
endmodule
bind exec_unit exec_unit_sva i_exec_unit_sva (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .clock_stop(clock_stop), .global_interrupt_enable(global_interrupt_enable));

// ==== testbench/tb_top.sv ====
// Random and corner instruction runs against a reference model
`timescale 1ns/1ps
module tb_top;
    import exec_pkg::*;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        clock_stop;
    logic        gie;
    logic [31:0] q;
    logic        e;
    logic [31:0] x;
    logic [11:0] o;
    logic [11:0] pc;
    logic [11:0] s;
    logic [7:0]  a;
    logic [7:0]  m;
    logic [3:0]  f;
    int          err_count;
    int          num_checks;
    int          seed;
    int          n;
    exec_unit i_exec_unit (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .clock_stop(clock_stop), .global_interrupt_enable(gie));
    always #2.5 pclk = ~pclk;
    ////////////////////////////////////////////////////////////////////////////////
    task end_of_test;
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task chk(input logic [32:0] got, input logic [32:0] exp);
        num_checks++;
        if (got !== exp) begin
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
            err_count++;
        end
    endtask
    // Idle cycle after each transfer keeps one assignment per time step
    task bus(input logic w, input logic [11:0] ad, input logic [31:0] d);
        int k;
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, ad, d};
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        // Registered answer is settled at the falling edge before its commit edge
        do begin @(negedge pclk); k++; end while (pready !== 1'b1 && k < 20);
        {e, q} = {pslverr, prdata};
        if (k >= 20) begin err_count++; end_of_test(); end
        @(posedge pclk);
        {psel, penable} <= 2'b00;
        @(posedge pclk);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Packs next pc, flags, accumulator and memory byte
    function automatic logic [31:0] model(input logic [4:0] op, input logic [11:0] o, input logic [7:0] a, m,
                                          input logic [3:0] f, input logic [11:0] pc, s);
        logic [7:0] r;
        logic [1:0] d;
        {d, r} = 10'h0;
        pc = pc + 12'h001;
        case (op)
            5'h01: f[3:2] = 2'b01;
            5'h02: {d, r} = {2'd2, m + 8'h01};
            5'h03: {d, r} = {2'd1, m + 8'h01};
            5'h04: pc = o;
            5'h05: {d, r} = {2'd1, m};
            5'h06: {d, r} = {2'd1, o[7:0]};
            5'h07: {d, r} = {2'd2, a};
            5'h08: {d, r} = {2'd1, a | m};
            5'h09: {d, r} = {2'd1, a | o[7:0]};
            5'h0a: {d, r} = {2'd2, a | m};
            5'h0b, 5'h0d: pc = s;
            5'h0c: {pc, d, r} = {s, 2'd1, o[7:0]};
            5'h0e: {d, r} = {2'd2, m[6:0], m[7]};
            5'h0f: {d, r} = {2'd1, m[6:0], m[7]};
            5'h10: {d, r} = {2'd2, m[6:0], f[1]};
            5'h11: {d, r} = {2'd1, m[6:0], f[1]};
            5'h12: {d, r} = {2'd2, m[0], m[7:1]};
            5'h13: {d, r} = {2'd1, m[0], m[7:1]};
            5'h14: {d, r} = {2'd2, f[1], m[7:1]};
            default: d = 2'd0;
        endcase
        if (op inside {5'h02, 5'h03, 5'h08, 5'h09, 5'h0a}) f[0] = (r == 8'h00);
        if (op == 5'h10 || op == 5'h11) f[1] = m[7];
        if (op == 5'h14) f[1] = m[0];
        if (d == 2'd1) a = r;
        if (d == 2'd2) m = r;
        return {pc, f, a, m};
    endfunction
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        {pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {err_count, num_checks, seed} = {32'd0, 32'd0, 32'd56};
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        bus(1'b0, OFS_CTRL, 32'h0);
        chk({e, q}, 33'h0);
        bus(1'b0, 12'h040, 32'h0);
        chk({e, q}, 33'h100000000);
        for (int it = 0; it < 3; it++) begin
            for (int op = 0; op <= 20; op++) begin
                {o, a, m, f} = $random(seed);
                x = $random(seed);
                {pc, s} = x[23:0];
                // Zero results for increment and OR corners
                if (it < 2) {a, m, o[7:0]} = {8'h00, (it == 0) ? 8'hff : 8'h00, 8'h00};
                bus(1'b1, OFS_ACC, {24'h0, a});
                bus(1'b1, OFS_FLAGS, {28'h0, f});
                bus(1'b1, OFS_PC, {20'h0, pc});
                bus(1'b1, OFS_MEM_ADDR, {25'h0, o[6:0]});
                bus(1'b1, OFS_MEM_DATA, {24'h0, m});
                bus(1'b1, OFS_STACK, {20'h0, s});
                bus(1'b1, OFS_INTCTL, 32'h0);
                bus(1'b1, OFS_INSTR, {15'h0, o, op[4:0]});
                bus(1'b1, OFS_CTRL, 32'h1);
                n = 0;
                do begin bus(1'b0, OFS_STATUS, 32'h0); n++; end while (q[STAT_BUSY_BIT] !== 1'b0 && n < 20);
                if (n >= 20) begin err_count++; end_of_test(); end
                x = model(op[4:0], o, a, m, f, pc, s);
                bus(1'b0, OFS_ACC, 32'h0);
                chk({e, q}, {25'h0, x[15:8]});
                bus(1'b0, OFS_FLAGS, 32'h0);
                chk({e, q}, {29'h0, x[19:16]});
                bus(1'b0, OFS_PC, 32'h0);
                chk({e, q}, {21'h0, x[31:20]});
                bus(1'b0, OFS_MEM_DATA, 32'h0);
                chk({e, q}, {25'h0, x[7:0]});
                chk({32'h0, gie}, {32'h0, op == 13});
                chk({32'h0, clock_stop}, {32'h0, op == 1});
                if (op == 1) begin bus(1'b0, OFS_WDT, 32'h0); chk({e, q}, 33'h0); bus(1'b1, OFS_CTRL, 32'h2); end
                $display("test pass %0d opcode %h done", it, op);
            end
        end
        end_of_test();
    end
endmodule
